// *** hw/ppb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppb_top (
    input  wire logic                       SYS_CLK,
    input  wire logic                       RST,
    input  wire logic [11:0]                AVS_ADDRESS,
    input  wire logic                       AVS_READ,
    input  wire logic                       AVS_WRITE,
    input  wire logic [3:0]                 AVS_BYTEENABLE,
    input  wire logic [31:0]                AVS_WRITEDATA,
    output logic      [31:0]                AVS_READDATA,
    output logic                            AVS_WAITREQUEST,
    output logic                            IRQ,
    output logic      [ppb_pkg::NUM_CH-1:0] TIMER_DOWN
);
    import ppb_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][15:0] ctrl;
        logic [7:0]       clksel;
        logic [1:0][15:0] cnt;
        logic [1:0]       down;
        logic [1:0]       ce_prev;
        logic [1:0][3:0]  thin;
        logic [3:0]       status;
        logic [3:0]       irq_en;
        logic             irq;
        logic             waitreq;
        logic [31:0]      rdata;
    } ppb_top_state_t;

    ppb_top_state_t   st;
    ppb_top_state_t   next_st;

    logic [31:0]      rd;
    logic             wr_go;
    logic             rd_setup;
    logic [3:0]       set_bits;
    logic [3:0]       clr_bits;
    logic [1:0]       pb_wr;
    logic [1:0]       ev_bottom;
    logic [1:0]       ev_match;
    logic [1:0]       start_ev;
    logic [1:0]       prim_ev;
    logic [1:0]       thin_pass;
    logic [1:0]       tick;
    logic [1:0][15:0] pb_buf;
    logic [1:0][15:0] pb_cmp;
    logic [1:0][2:0]  chan_sel;

    function automatic logic ppb_hit(input logic [11:0] addr,
                                     input logic [11:0] reg_adr);
        ppb_hit = addr[11:2] == reg_adr[11:2];
    endfunction

    // thinning ratios 1/1 to 1/16; other codes pass every event
    function automatic logic [3:0] ppb_thin_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    ppb_thin_mask = 4'h0;
            3'h1:    ppb_thin_mask = 4'h1;
            3'h2:    ppb_thin_mask = 4'h3;
            3'h3:    ppb_thin_mask = 4'h7;
            3'h4:    ppb_thin_mask = 4'hF;
            default: ppb_thin_mask = 4'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // base clock and per-channel prescaler
    // ------------------------------------------------------------
    ppb_prescaler i_ppb_prescaler (
        .clk      (SYS_CLK),
        .rst      (RST),
        .base_sel (st.clksel[1:0]),
        .chan_sel (chan_sel),
        .tick     (tick)
    );

    // ------------------------------------------------------------
    // period buffer and compare, one unit per channel
    // ------------------------------------------------------------
    ppb_period_if pif [NUM_CH] ();

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
            assign chan_sel[g]       = st.ctrl[g][CTRL_PRM_LSB +: 3];
            assign pif[g].load_wr    = pb_wr[g];
            assign pif[g].load_data  = AVS_WRITEDATA[15:0];
            assign pif[g].count_en   = st.ctrl[g][CTRL_CE_BIT];
            assign pif[g].tick       = tick[g];
            assign pif[g].bottom     = ev_bottom[g];
            assign pif[g].xfer_en    = st.ctrl[g][CTRL_PXFER_BIT];
            assign pb_buf[g]         = pif[g].buffer;
            assign pb_cmp[g]         = pif[g].compare;

            ppb_period_unit i_ppb_period_unit (
                .clk (SYS_CLK),
                .rst (RST),
                .pif (pif[g].unit)
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st   = st;
        rd        = 32'h0000_0000;
        set_bits  = 4'h0;
        clr_bits  = 4'h0;
        pb_wr     = 2'b00;
        ev_bottom = 2'b00;
        ev_match  = 2'b00;
        start_ev  = 2'b00;
        prim_ev   = 2'b00;
        thin_pass = 2'b00;

        // one wait cycle per access: read data is fetched while
        // waitrequest is high, so it stands at the releasing edge
        wr_go    = AVS_WRITE && !st.waitreq;
        rd_setup = AVS_READ && st.waitreq;
        next_st.waitreq = !((AVS_READ || AVS_WRITE) && st.waitreq);

        // shared registers
        if (ppb_hit(AVS_ADDRESS, ADR_IRQ_STATUS)) begin
            rd = {28'h0, st.status};
        end
        if (ppb_hit(AVS_ADDRESS, ADR_IRQ_ENABLE)) begin
            rd = {28'h0, st.irq_en};
        end
        if (ppb_hit(AVS_ADDRESS, ADR_CLKSEL)) begin
            rd = {24'h0, st.clksel};
        end
        if (ppb_hit(AVS_ADDRESS, ADR_RUN_STATE)) begin
            rd = {28'h0, st.down, st.ctrl[1][CTRL_CE_BIT],
                  st.ctrl[0][CTRL_CE_BIT]};
        end
        if (wr_go && AVS_BYTEENABLE[0]) begin
            if (ppb_hit(AVS_ADDRESS, ADR_CLKSEL)) begin
                next_st.clksel = AVS_WRITEDATA[7:0];
            end
            if (ppb_hit(AVS_ADDRESS, ADR_IRQ_ENABLE)) begin
                next_st.irq_en = AVS_WRITEDATA[3:0];
            end
            if (ppb_hit(AVS_ADDRESS, ADR_IRQ_CLEAR)) begin
                clr_bits = AVS_WRITEDATA[3:0];
            end
        end

        for (int c = 0; c < NUM_CH; c++) begin
            // per-channel register access
            if (ppb_hit(AVS_ADDRESS, ADR_CTRL[c])) begin
                rd = {16'h0, st.ctrl[c]};
            end
            if (ppb_hit(AVS_ADDRESS, ADR_PBUF[c])) begin
                rd = {16'h0, pb_buf[c]};
            end
            if (ppb_hit(AVS_ADDRESS, ADR_CMP[c])) begin
                rd = {16'h0, pb_cmp[c]};
            end
            if (ppb_hit(AVS_ADDRESS, ADR_CNT[c])) begin
                rd = {16'h0, st.cnt[c]};
            end
            if (wr_go && ppb_hit(AVS_ADDRESS, ADR_CTRL[c])) begin
                if (AVS_BYTEENABLE[0]) begin
                    next_st.ctrl[c][7:0] =
                        AVS_WRITEDATA[7:0] & CTRL_WMASK[7:0];
                end
                if (AVS_BYTEENABLE[1]) begin
                    next_st.ctrl[c][15:8] =
                        AVS_WRITEDATA[15:8] & CTRL_WMASK[15:8];
                end
            end
            // a single-byte write would tear the period, so it is dropped
            pb_wr[c] = wr_go && ppb_hit(AVS_ADDRESS, ADR_PBUF[c]) &&
                       (AVS_BYTEENABLE[1:0] == 2'b11);

            // counter; a zero period is not supported
            if (!st.ctrl[c][CTRL_CE_BIT]) begin
                next_st.cnt[c]  = 16'h0000;
                next_st.down[c] = 1'b0;
                next_st.thin[c] = 4'h0;
            end else if (tick[c]) begin
                if (st.ctrl[c][CTRL_SHAPE_BIT]) begin
                    if (st.cnt[c] == pb_cmp[c]) begin
                        next_st.cnt[c] = 16'h0000;
                        ev_match[c]    = 1'b1;
                        ev_bottom[c]   = 1'b1;
                    end else begin
                        next_st.cnt[c] = st.cnt[c] + 16'h0001;
                    end
                end else if (!st.down[c]) begin
                    if (st.cnt[c] == pb_cmp[c]) begin
                        next_st.down[c] = 1'b1;
                        next_st.cnt[c]  = st.cnt[c] - 16'h0001;
                        ev_match[c]     = 1'b1;
                    end else begin
                        next_st.cnt[c] = st.cnt[c] + 16'h0001;
                    end
                end else begin
                    if (st.cnt[c] <= 16'h0001) begin
                        next_st.cnt[c]  = 16'h0000;
                        next_st.down[c] = 1'b0;
                        ev_bottom[c]    = 1'b1;
                    end else begin
                        next_st.cnt[c] = st.cnt[c] - 16'h0001;
                    end
                end
            end

            // start is the rising edge of count enable
            next_st.ce_prev[c] = st.ctrl[c][CTRL_CE_BIT];
            start_ev[c] = st.ctrl[c][CTRL_CE_BIT] && !st.ce_prev[c] &&
                          st.ctrl[c][CTRL_STINT_BIT];

            // thinning acts on the mode's period interrupt only
            prim_ev[c] = st.ctrl[c][CTRL_SHAPE_BIT] ? ev_match[c]
                                                     : ev_bottom[c];
            thin_pass[c] = (st.thin[c] &
                ppb_thin_mask(st.ctrl[c][CTRL_THIN_LSB +: 3])) == 4'h0;
            if (prim_ev[c]) begin
                next_st.thin[c] = st.thin[c] + 4'h1;
            end

            if (st.ctrl[c][CTRL_SHAPE_BIT]) begin
                set_bits[2*c + ST_MATCH] = (ev_match[c] && thin_pass[c]) ||
                                           start_ev[c];
            end else begin
                set_bits[2*c + ST_MATCH]  = ev_match[c];
                set_bits[2*c + ST_BOTTOM] = (ev_bottom[c] && thin_pass[c]) ||
                                            start_ev[c];
            end
        end

        // an event in the clearing cycle survives
        next_st.status = (st.status & ~clr_bits) | set_bits;
        next_st.irq    = |(next_st.status & next_st.irq_en);

        if (rd_setup) begin
            next_st.rdata = rd;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            st         <= '0;
            st.ctrl    <= {CTRL_RESET, CTRL_RESET};
            st.clksel  <= CLKSEL_RESET;
            st.waitreq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign AVS_READDATA    = st.rdata;
    assign AVS_WAITREQUEST = st.waitreq;
    assign IRQ             = st.irq;
    assign TIMER_DOWN      = st.down;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_ctrl_word: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1:0] == 2'b11 &&
         AVS_ADDRESS[11:2] == ADR_T0_CTRL[11:2])
        |=> st.ctrl[0] == ($past(AVS_WRITEDATA[15:0]) & CTRL_WMASK))
        else $error("control word write not stored");

    chk_ctrl_byte: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1:0] == 2'b10 &&
         AVS_ADDRESS[11:2] == ADR_T1_CTRL[11:2])
        |=> st.ctrl[1][7:0] == $past(st.ctrl[1][7:0]) &&
            st.ctrl[1][15:8] == $past(AVS_WRITEDATA[15:8]))
        else $error("control high byte write disturbed low byte");

    chk_clksel_byte: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] &&
         AVS_ADDRESS[11:2] == ADR_CLKSEL[11:2])
        |=> st.clksel == $past(AVS_WRITEDATA[7:0]))
        else $error("clock select byte write not stored");

    chk_pbuf_whole: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1:0] != 2'b11 &&
         AVS_ADDRESS[11:2] == ADR_T0_PBUF[11:2])
        |=> $stable(pb_buf[0]))
        else $error("partial write changed period buffer");

    chk_tri_reverse: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (st.ctrl[0][CTRL_CE_BIT] && !st.ctrl[0][CTRL_SHAPE_BIT] &&
         tick[0] && !st.down[0] && st.cnt[0] == pb_cmp[0])
        |=> st.down[0] && TIMER_DOWN[0])
        else $error("triangular counter did not reverse at match");

    chk_saw_clear: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (st.ctrl[1][CTRL_CE_BIT] && st.ctrl[1][CTRL_SHAPE_BIT] &&
         tick[1] && st.cnt[1] == pb_cmp[1])
        |=> st.cnt[1] == 16'h0000)
        else $error("sawtooth counter did not clear at match");

    chk_start_irq: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (st.ctrl[0][CTRL_CE_BIT] && !st.ce_prev[0] &&
         st.ctrl[0][CTRL_STINT_BIT] && !st.ctrl[0][CTRL_SHAPE_BIT])
        |=> st.status[ST_BOTTOM])
        else $error("start interrupt not raised");

    chk_saw_start: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (st.ctrl[1][CTRL_CE_BIT] && !st.ce_prev[1] &&
         st.ctrl[1][CTRL_STINT_BIT] && st.ctrl[1][CTRL_SHAPE_BIT])
        |=> st.status[2 + ST_MATCH])
        else $error("sawtooth start interrupt not raised");

endmodule

`default_nettype wire

// *** inc/ppb_pkg.sv ***
package ppb_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int NUM_CH = 2;

    // register indices; the bus byte address is four times the index
    localparam logic [31:0] IDX_T0_PBUF     = 32'hFFFFF578;
    localparam logic [31:0] IDX_T0_CTRL     = 32'h0FFFF57A;
    localparam logic [31:0] IDX_T1_PBUF     = 32'h0FFFF5B8;
    localparam logic [31:0] IDX_T1_CTRL     = 32'h0FFFF5BA;
    localparam logic [31:0] IDX_IRQ_STATUS  = 32'h0FFFF5C0;
    localparam logic [31:0] IDX_IRQ_CLEAR   = 32'h0FFFF5C4;
    localparam logic [31:0] IDX_IRQ_ENABLE  = 32'h0FFFF5C8;
    localparam logic [31:0] IDX_CLKSEL      = 32'h0FFFF5CC;
    localparam logic [31:0] IDX_T0_CMP      = 32'h0FFFF5D0;
    localparam logic [31:0] IDX_T1_CMP      = 32'h0FFFF5D2;
    localparam logic [31:0] IDX_T0_CNT      = 32'h0FFFF5D4;
    localparam logic [31:0] IDX_T1_CNT      = 32'h0FFFF5D6;
    localparam logic [31:0] IDX_RUN_STATE   = 32'h0FFFF5D8;

    // only the low ten index bits are decoded
    localparam logic [11:0] ADR_T0_PBUF    = {IDX_T0_PBUF[9:0], 2'b00};
    localparam logic [11:0] ADR_T0_CTRL    = {IDX_T0_CTRL[9:0], 2'b00};
    localparam logic [11:0] ADR_T1_PBUF    = {IDX_T1_PBUF[9:0], 2'b00};
    localparam logic [11:0] ADR_T1_CTRL    = {IDX_T1_CTRL[9:0], 2'b00};
    localparam logic [11:0] ADR_IRQ_STATUS = {IDX_IRQ_STATUS[9:0], 2'b00};
    localparam logic [11:0] ADR_IRQ_CLEAR  = {IDX_IRQ_CLEAR[9:0], 2'b00};
    localparam logic [11:0] ADR_IRQ_ENABLE = {IDX_IRQ_ENABLE[9:0], 2'b00};
    localparam logic [11:0] ADR_CLKSEL     = {IDX_CLKSEL[9:0], 2'b00};
    localparam logic [11:0] ADR_T0_CMP     = {IDX_T0_CMP[9:0], 2'b00};
    localparam logic [11:0] ADR_T1_CMP     = {IDX_T1_CMP[9:0], 2'b00};
    localparam logic [11:0] ADR_T0_CNT     = {IDX_T0_CNT[9:0], 2'b00};
    localparam logic [11:0] ADR_T1_CNT     = {IDX_T1_CNT[9:0], 2'b00};
    localparam logic [11:0] ADR_RUN_STATE  = {IDX_RUN_STATE[9:0], 2'b00};

    localparam logic [1:0][11:0] ADR_PBUF = {ADR_T1_PBUF, ADR_T0_PBUF};
    localparam logic [1:0][11:0] ADR_CTRL = {ADR_T1_CTRL, ADR_T0_CTRL};
    localparam logic [1:0][11:0] ADR_CMP  = {ADR_T1_CMP, ADR_T0_CMP};
    localparam logic [1:0][11:0] ADR_CNT  = {ADR_T1_CNT, ADR_T0_CNT};

    // ------------------------------------------------------------
    // control and status register fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_CE_BIT     = 15;
    localparam int CTRL_STINT_BIT  = 14;
    localparam int CTRL_THIN_LSB   = 11;
    localparam int CTRL_PRM_LSB    = 8;
    localparam int CTRL_PXFER_BIT  = 4;
    localparam int CTRL_SHAPE_BIT  = 1;
    localparam int ST_BOTTOM       = 0;
    localparam int ST_MATCH        = 1;

    localparam logic [15:0] CTRL_RESET   = 16'h0508;
    localparam logic [15:0] CTRL_WMASK   = 16'hFF3F;
    localparam logic [15:0] PBUF_RESET   = 16'hFFFF;
    localparam logic [7:0]  CLKSEL_RESET = 8'h00;

endpackage

// *** inc/ppb_period_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface ppb_period_if;
    logic        load_wr;
    logic [15:0] load_data;
    logic        count_en;
    logic        tick;
    logic        bottom;
    logic        xfer_en;
    logic [15:0] buffer;
    logic [15:0] compare;

    modport owner (
        output load_wr, load_data, count_en, tick, bottom, xfer_en,
        input  buffer, compare
    );
    modport unit (
        input  load_wr, load_data, count_en, tick, bottom, xfer_en,
        output buffer, compare
    );
endinterface

`default_nettype wire

// *** hw/ppb_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppb_prescaler (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [1:0]      base_sel,
    input  wire logic [1:0][2:0] chan_sel,
    output logic      [1:0]      tick
);
    import ppb_pkg::*;

    typedef struct packed {
        logic [7:0] base_cnt;
        logic [7:0] div_cnt;
        logic [1:0] tick;
    } ppb_pre_state_t;

    ppb_pre_state_t st;
    ppb_pre_state_t next_st;
    logic           base_tick;

    function automatic logic [7:0] ppb_pow_mask(input logic [2:0] sel);
        ppb_pow_mask = ~(8'hFF << sel);
    endfunction

    // one shared divider chain keeps both channels phase aligned
    always_comb begin
        next_st = st;
        next_st.base_cnt = st.base_cnt + 8'h01;
        base_tick = (st.base_cnt & ppb_pow_mask({1'b0, base_sel})) == 8'h00;
        if (base_tick) begin
            next_st.div_cnt = st.div_cnt + 8'h01;
        end
        for (int c = 0; c < NUM_CH; c++) begin
            next_st.tick[c] = base_tick &&
                ((st.div_cnt & ppb_pow_mask(chan_sel[c])) == 8'h00);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    chk_fast_tick: assert property (
        @(posedge clk) disable iff (rst)
        ($past(base_sel) == 2'h0 && $past(chan_sel[0]) == 3'h0) |-> tick[0])
        else $error("undivided base clock gave no tick");

endmodule

`default_nettype wire

// *** hw/ppb_period_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppb_period_unit (
    input  wire logic   clk,
    input  wire logic   rst,
    ppb_period_if.unit  pif
);
    import ppb_pkg::*;

    typedef struct packed {
        logic [15:0] buffer;
        logic [15:0] compare;
        logic        pending;
    } ppb_pu_state_t;

    ppb_pu_state_t st;
    ppb_pu_state_t next_st;

    always_comb begin
        next_st = st;
        if (!pif.count_en) begin
            if (st.pending && pif.tick) begin
                next_st.compare = st.buffer;
                next_st.pending = 1'b0;
            end
        end else if (pif.bottom && pif.xfer_en) begin
            next_st.compare = st.buffer;
            next_st.pending = 1'b0;
        end
        if (pif.load_wr) begin
            next_st.buffer  = pif.load_data;
            next_st.pending = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= {PBUF_RESET, PBUF_RESET, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign pif.buffer  = st.buffer;
    assign pif.compare = st.compare;

    chk_stop_load: assert property (
        @(posedge clk) disable iff (rst)
        (!pif.count_en && st.pending && pif.tick)
        |=> st.compare == $past(st.buffer))
        else $error("stopped timer did not load compare");

    chk_bottom_load: assert property (
        @(posedge clk) disable iff (rst)
        (pif.count_en && pif.bottom && pif.xfer_en)
        |=> st.compare == $past(st.buffer))
        else $error("bottom event did not load compare");

    chk_gate_hold: assert property (
        @(posedge clk) disable iff (rst)
        (pif.count_en && !(pif.bottom && pif.xfer_en)) |=> $stable(st.compare))
        else $error("compare changed without gated transfer");

endmodule

`default_nettype wire

// *** sim/tb_ppb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb_ppb_top;
    import ppb_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        sys_clk, rst, rd, wr, irq, wait_req;
    logic [11:0] adr;
    logic [3:0]  be;
    logic [31:0] wdata, rdata, e_now;
    logic [1:0]  down;
    logic [15:0] val;
    logic [31:0] exp_q[$];
    int          failures, checks_done, i;

    ppb_top i_ppb_top (
        .SYS_CLK        (sys_clk),
        .RST            (rst),
        .AVS_ADDRESS    (adr),
        .AVS_READ       (rd),
        .AVS_WRITE      (wr),
        .AVS_BYTEENABLE (be),
        .AVS_WRITEDATA  (wdata),
        .AVS_READDATA   (rdata),
        .AVS_WAITREQUEST(wait_req),
        .IRQ            (irq),
        .TIMER_DOWN     (down)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // bus master and read monitor
    // ------------------------------------------------------------
    // one idle edge before each request, so no signal is set twice at once
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        @(posedge sys_clk);
        adr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge sys_clk);
        end while (wait_req !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wreg(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] b = 4'h3);
        acc(1'b1, a, d, b);
    endtask

    task automatic rreg(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 32'h0, 4'hF);
    endtask

    always @(posedge sys_clk) begin
        if (rd === 1'b1 && wait_req === 1'b0 && exp_q.size() > 0) begin
            e_now = exp_q.pop_front();
            `CHK(rdata, e_now)
        end
    end

    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the tests take about 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst <= 1'b1;
        rd <= 1'b0;
        wr <= 1'b0;
        adr <= '0;
        be <= '0;
        wdata <= '0;
        failures = 0;
        checks_done = 0;
        void'($urandom(32'h742C58C8));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 2; i++) begin
            rreg(ADR_CTRL[i], {16'h0, CTRL_RESET});
            rreg(ADR_PBUF[i], {16'h0, PBUF_RESET});
            rreg(ADR_CMP[i], 32'h0000FFFF);
        end
        rreg(ADR_IRQ_STATUS, 32'h0);
        rreg(12'hFFC, 32'h0);
        wreg(ADR_CLKSEL, 32'hA4, 4'h1);
        rreg(ADR_CLKSEL, 32'hA4);
        $display("reset and map test done");
        // partial write refused; lanes of the control register
        wreg(ADR_T1_PBUF, 32'h1234, 4'h1);
        rreg(ADR_T1_PBUF, 32'hFFFF);
        wreg(ADR_T0_PBUF, 32'h5678, 4'h2);
        rreg(ADR_T0_PBUF, 32'hFFFF);
        wreg(ADR_T1_CTRL, 32'hFF, 4'h1);
        rreg(ADR_T1_CTRL, 32'h053F);
        wreg(ADR_T1_CTRL, 32'h0200, 4'h2);
        rreg(ADR_T1_CTRL, 32'h023F);
        wreg(ADR_T0_CTRL, 32'h0008);
        rreg(ADR_T0_CTRL, 32'h0008);
        $display("byte access test done");
        // stopped timer: compare follows the buffer at the next tick
        val = 16'($urandom_range(32'hFFFE, 32'h1));
        wreg(ADR_T0_PBUF, {16'h0, val});
        rreg(ADR_T0_PBUF, {16'h0, val});
        repeat (40) @(posedge sys_clk);
        rreg(ADR_T0_CMP, {16'h0, val});
        wreg(ADR_T0_CMP, 32'h1111);
        rreg(ADR_T0_CMP, {16'h0, val});
        wreg(ADR_T0_PBUF, 32'h4);
        repeat (40) @(posedge sys_clk);
        rreg(ADR_T0_CMP, 32'h4);
        $display("stopped load test done");
        // running triangular timer with start interrupt
        wreg(ADR_IRQ_ENABLE, 32'h3);
        wreg(ADR_T0_CTRL, 32'h4510);
        wreg(ADR_T0_CTRL, 32'hC510);
        repeat (4) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        rreg(ADR_IRQ_STATUS, 32'h1);
        wreg(ADR_T0_PBUF, 32'h6);
        rreg(ADR_T0_CMP, 32'h4);
        repeat (300) @(posedge sys_clk);
        rreg(ADR_T0_CMP, 32'h6);
        for (i = 0; i < 400 && down[0] !== 1'b1; i++) @(posedge sys_clk);
        `CHK(down[0], 1'b1)
        wreg(ADR_T0_CTRL, 32'h8500);
        wreg(ADR_T0_PBUF, 32'h9);
        repeat (600) @(posedge sys_clk);
        rreg(ADR_T0_CMP, 32'h6);
        wreg(ADR_T0_CTRL, 32'h0500);
        wreg(ADR_IRQ_CLEAR, 32'hF);
        rreg(ADR_IRQ_STATUS, 32'h0);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        $display("running transfer test done");
        // sawtooth start flag, masked then enabled
        wreg(ADR_IRQ_ENABLE, 32'h0);
        wreg(ADR_T1_CTRL, 32'h4502);
        wreg(ADR_T1_CTRL, 32'hC502);
        repeat (4) @(posedge sys_clk);
        rreg(ADR_IRQ_STATUS, 32'h8);
        `CHK(irq, 1'b0)
        wreg(ADR_IRQ_ENABLE, 32'h8);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        `CHK(down[1], 1'b0)
        wreg(ADR_T1_CTRL, 32'h0502);
        wreg(ADR_IRQ_CLEAR, 32'h8);
        rreg(ADR_IRQ_STATUS, 32'h0);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        $display("sawtooth interrupt test done");
        // halved base clock, sawtooth of three ticks, every second match thinned
        wreg(ADR_CLKSEL, 32'hA5, 4'h1);
        wreg(ADR_T1_PBUF, 32'h2);
        repeat (70) @(posedge sys_clk);
        rreg(ADR_T1_CMP, 32'h2);
        wreg(ADR_T1_CTRL, 32'h8D02);
        for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        wreg(ADR_IRQ_CLEAR, 32'h8);
        repeat (250) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        wreg(ADR_T1_CTRL, 32'h0502);
        $display("thinning test done");
        close_out();
    end
endmodule

`default_nettype wire
